// File: hw/flash_host_map.vh
// register offsets, fields and timing constants of the flash host controller
`ifndef FLASH_HOST_MAP_VH
`define FLASH_HOST_MAP_VH
// ----------------------------------------------------------------------------
// software registers (byte addresses)
// ----------------------------------------------------------------------------
`define REG_CMD      8'h00
`define REG_ADDR     8'h04
`define REG_WDATA    8'h08
`define REG_STATUS   8'h0C
`define REG_RDATA    8'h10
`define REG_PREFIX   8'h14
// command field codes in REG_CMD[2:0]
`define CMD_READ     3'h1
`define CMD_LOAD     3'h2
`define CMD_POLL     3'h3
`define CMD_SEQ      3'h4
// status bits
`define ST_BUSY      0
`define ST_DONE      1
`define ST_TIMEOUT   2
// sequence selection in REG_CMD[5:4]
`define SEQ_PROT_ON  2'h0
`define SEQ_PROT_OFF 2'h1
`define SEQ_ERASE    2'h2
// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define CLK_MHZ          250
`define STROBE_NS        100
`define STROBE_CYC       ((`STROBE_NS * `CLK_MHZ + 999) / 1000)
`define LOAD_GAP_NS      100
`define LOAD_GAP_CYC     ((`LOAD_GAP_NS * `CLK_MHZ + 999) / 1000)
`define READ_ACC_NS      150
`define READ_ACC_CYC     ((`READ_ACC_NS * `CLK_MHZ + 999) / 1000)
`define LOAD_WIN_US      150
`define PROG_TIME_MS     10
`define LOCKOUT_MS       5
`define TIMEOUT_MS       20
`endif

// File: hw/flash_host.v
// host controller driving a byte-wide sector flash from AXI4-Lite registers
`timescale 1ns/1ps
`default_nettype none
`include "flash_host_map.vh"
module flash_host #(
  parameter [31:0] LOAD_WIN_CYC = `LOAD_WIN_US * `CLK_MHZ,
  parameter [31:0] LOCKOUT_CYC  = `LOCKOUT_MS * 1000 * `CLK_MHZ,
  parameter [31:0] TIMEOUT_CYC  = `TIMEOUT_MS * 1000 * `CLK_MHZ,
  parameter [143:0] SEQ_TABLE   = 144'h0000_0000_0000_0000_0000_0000_0000_0000_0000
) (
  input  wire        REF_CLK,
  input  wire        ARST_N,
  input  wire [7:0]  S_AWADDR,
  input  wire        S_AWVALID,
  output reg         S_AWREADY,
  input  wire [31:0] S_WDATA,
  input  wire [3:0]  S_WSTRB,
  input  wire        S_WVALID,
  output reg         S_WREADY,
  output reg  [1:0]  S_BRESP,
  output reg         S_BVALID,
  input  wire        S_BREADY,
  input  wire [7:0]  S_ARADDR,
  input  wire        S_ARVALID,
  output reg         S_ARREADY,
  output reg  [31:0] S_RDATA,
  output reg  [1:0]  S_RRESP,
  output reg         S_RVALID,
  input  wire        S_RREADY,
  output reg  [15:0] FL_ADDR,
  output reg         FL_CHIP_SEL_N,
  output reg         FL_OUT_GATE_N,
  output reg         FL_WR_STROBE_N,
  output reg  [7:0]  FL_DQ_O,
  output reg         FL_DQ_OE,
  input  wire [7:0]  FL_DQ_I
);
  localparam [5:0] S_IDLE = 6'b000001, S_RD = 6'b000010, S_WR = 6'b000100,
                   S_GAP = 6'b001000, S_POLL = 6'b010000, S_WAIT = 6'b100000;
  // ------------------------------------------------------------------------
  // pin synchroniser and registers
  // ------------------------------------------------------------------------
  reg [7:0]  dq_m_r, dq_s_r;
  reg [5:0]  st_r;
  reg [31:0] cnt_r, win_r, lock_r, tmo_r;
  reg [15:0] addr_r;
  reg [7:0]  wdata_r, rdata_r, last_r, prev_r;
  reg [2:0]  cmd_r;
  reg [1:0]  seq_sel_r;
  reg [2:0]  seq_idx_r, seq_len_r;
  reg        busy_r, done_r, tmo_flag_r, in_seq_r, have_prev_r;
  reg        aw_got_r, w_got_r;
  reg [7:0]  aw_r;
  reg [31:0] w_r;

  function [23:0] seq_word;
    input [1:0] sel;
    input [2:0] idx;
    reg   [3:0] pos;
    begin
      pos = (sel == `SEQ_ERASE) ? {1'b0, idx} + 4'd0 :
            (sel == `SEQ_PROT_ON) ? {1'b0, idx} + 4'd0 : {1'b0, idx} + 4'd3;
      if (sel == `SEQ_ERASE)
        pos = {1'b0, idx};
      seq_word = SEQ_TABLE[pos*24 +: 24];
    end
  endfunction

  wire        wr_go = aw_got_r && w_got_r && !S_BVALID;
  wire [23:0] sw    = seq_word(seq_sel_r, seq_idx_r);

  always @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      dq_m_r <= 8'h00;
      dq_s_r <= 8'h00;
    end else begin
      dq_m_r <= FL_DQ_I;
      dq_s_r <= dq_m_r;
    end
  end

  // ------------------------------------------------------------------------
  // AXI4-Lite slave
  // ------------------------------------------------------------------------
  always @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      S_AWREADY <= 1'b0; S_WREADY <= 1'b0; S_BVALID <= 1'b0;
      S_BRESP <= 2'h0; S_ARREADY <= 1'b0; S_RVALID <= 1'b0;
      S_RDATA <= 32'h0000_0000; S_RRESP <= 2'h0;
      aw_got_r <= 1'b0; w_got_r <= 1'b0; aw_r <= 8'h00; w_r <= 32'h0000_0000;
    end else begin
      S_AWREADY <= !aw_got_r && S_AWVALID && !S_AWREADY;
      S_WREADY  <= !w_got_r && S_WVALID && !S_WREADY;
      if (S_AWVALID && S_AWREADY) begin
        aw_got_r <= 1'b1;
        aw_r     <= S_AWADDR;
      end
      if (S_WVALID && S_WREADY) begin
        w_got_r <= 1'b1;
        w_r     <= S_WDATA;
      end
      if (wr_go) begin
        S_BVALID <= 1'b1;
        S_BRESP  <= (aw_r <= `REG_PREFIX && aw_r[1:0] == 2'b00) ? 2'h0 : 2'h2;
        aw_got_r <= 1'b0;
        w_got_r  <= 1'b0;
      end else if (S_BVALID && S_BREADY)
        S_BVALID <= 1'b0;
      S_ARREADY <= S_ARVALID && !S_ARREADY && !S_RVALID;
      if (S_ARVALID && S_ARREADY) begin
        S_RVALID <= 1'b1;
        S_RRESP  <= 2'h0;
        if (S_ARADDR == `REG_ADDR)
          S_RDATA <= {16'h0000, addr_r};
        else if (S_ARADDR == `REG_WDATA)
          S_RDATA <= {24'h00_0000, wdata_r};
        else if (S_ARADDR == `REG_STATUS)
          S_RDATA <= {29'h0, tmo_flag_r, done_r, busy_r};
        else if (S_ARADDR == `REG_RDATA)
          S_RDATA <= {24'h00_0000, rdata_r};
        else if (S_ARADDR == `REG_CMD)
          S_RDATA <= {26'h0, seq_sel_r, 1'b0, cmd_r};
        else begin
          S_RDATA <= 32'h0000_0000;
          S_RRESP <= 2'h2;
        end
      end else if (S_RVALID && S_RREADY)
        S_RVALID <= 1'b0;
    end
  end

  // ------------------------------------------------------------------------
  // flash pin sequencer
  // ------------------------------------------------------------------------
  always @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      st_r <= S_IDLE; cnt_r <= 32'h0000_0000; win_r <= 32'h0000_0000;
      lock_r <= 32'h0000_0000; tmo_r <= 32'h0000_0000;
      addr_r <= 16'h0000; wdata_r <= 8'h00; rdata_r <= 8'h00;
      last_r <= 8'h00; prev_r <= 8'h00; cmd_r <= 3'h0; seq_sel_r <= 2'h0;
      seq_idx_r <= 3'h0; seq_len_r <= 3'h0; busy_r <= 1'b0; done_r <= 1'b0;
      tmo_flag_r <= 1'b0; in_seq_r <= 1'b0; have_prev_r <= 1'b0;
      FL_ADDR <= 16'h0000; FL_CHIP_SEL_N <= 1'b1; FL_OUT_GATE_N <= 1'b1;
      FL_WR_STROBE_N <= 1'b1; FL_DQ_O <= 8'h00; FL_DQ_OE <= 1'b0;
    end else begin
      if (lock_r < LOCKOUT_CYC)
        lock_r <= lock_r + 32'd1;
      // load window time left after the data hold that follows the last strobe rise, counted down to zero
      if (win_r != 32'h0000_0000)
        win_r <= win_r - 32'd1;
      if (wr_go && aw_r == `REG_ADDR)
        addr_r <= w_r[15:0];
      if (wr_go && aw_r == `REG_WDATA)
        wdata_r <= w_r[7:0];
      if (wr_go && aw_r == `REG_STATUS) begin
        done_r     <= done_r & ~w_r[`ST_DONE];
        tmo_flag_r <= tmo_flag_r & ~w_r[`ST_TIMEOUT];
      end
      case (st_r)
        S_IDLE: begin
          if (wr_go && aw_r == `REG_CMD && w_r[2:0] != 3'h0 &&
              (w_r[2:0] == `CMD_READ || lock_r >= LOCKOUT_CYC)) begin
            cmd_r     <= w_r[2:0];
            seq_sel_r <= w_r[5:4];
            busy_r    <= 1'b1;
            cnt_r     <= 32'h0000_0000;
            seq_idx_r <= 3'h0;
            seq_len_r <= (w_r[5:4] == `SEQ_ERASE) ? 3'd6 : 3'd3;
            have_prev_r <= 1'b0;
            tmo_r     <= 32'h0000_0000;
            in_seq_r  <= (w_r[2:0] == `CMD_SEQ);
            if (w_r[2:0] == `CMD_READ || w_r[2:0] == `CMD_POLL) begin
              // read cycle with write strobe high
              FL_ADDR       <= addr_r;
              FL_CHIP_SEL_N <= 1'b0;
              FL_OUT_GATE_N <= 1'b0;
              st_r          <= S_RD;
            end else if (w_r[2:0] == `CMD_SEQ) begin
              // controller sends the selected sequence bytes from SEQ_TABLE itself
              st_r <= S_GAP;
            end else begin
              // one byte per command, software covers the sector
              st_r <= S_GAP;
            end
          end
        end
        S_GAP: begin
          // gate high and drive bus before strobing
          FL_OUT_GATE_N <= 1'b1;
          // sequence bytes use normal load timing
          // address set before the strobe falls and held through it
          FL_ADDR  <= in_seq_r ? sw[23:8] : addr_r;
          FL_DQ_O  <= in_seq_r ? sw[7:0] : wdata_r;
          FL_DQ_OE <= 1'b1;
          cnt_r    <= cnt_r + 32'd1;
          if (cnt_r + 32'd1 >= `LOAD_GAP_CYC) begin
            // chip select and write strobe low together
            FL_CHIP_SEL_N  <= 1'b0;
            FL_WR_STROBE_N <= 1'b0;
            cnt_r          <= 32'h0000_0000;
            st_r           <= S_WR;
          end
        end
        S_WR: begin
          cnt_r <= cnt_r + 32'd1;
          // strobe width well beyond the noise filter
          if (cnt_r + 32'd1 >= `STROBE_CYC) begin
            FL_WR_STROBE_N <= 1'b1;
            FL_CHIP_SEL_N  <= 1'b1;
            cnt_r          <= 32'h0000_0000;
            st_r           <= S_WAIT;
          end
        end
        S_WAIT: begin
          // data held one gap after strobe rise
          cnt_r <= cnt_r + 32'd1;
          if (cnt_r + 32'd1 >= `LOAD_GAP_CYC) begin
            FL_DQ_OE <= 1'b0;
            cnt_r    <= 32'h0000_0000;
            win_r    <= LOAD_WIN_CYC;
            if (in_seq_r && seq_idx_r + 3'd1 < seq_len_r) begin
              // walk through all bytes of the sequence
              seq_idx_r <= seq_idx_r + 3'd1;
              st_r      <= S_GAP;
            end else begin
              // remember last loaded byte for polling
              last_r <= in_seq_r ? sw[7:0] : wdata_r;
              busy_r <= 1'b0;
              done_r <= 1'b1;
              st_r   <= S_IDLE;
            end
          end
        end
        S_RD: begin
          cnt_r <= cnt_r + 32'd1;
          tmo_r <= tmo_r + 32'd1;
          if (cnt_r + 32'd1 >= `READ_ACC_CYC + 2) begin
            FL_CHIP_SEL_N <= 1'b1;
            FL_OUT_GATE_N <= 1'b1;
            rdata_r       <= dq_s_r;
            // keep the earlier read so the toggle line can be compared
            prev_r        <= rdata_r;
            cnt_r         <= 32'h0000_0000;
            st_r          <= (cmd_r == `CMD_POLL) ? S_POLL : S_IDLE;
            if (cmd_r != `CMD_POLL) begin
              busy_r <= 1'b0;
              done_r <= 1'b1;
            end
          end
        end
        S_POLL: begin
          // finished when bit 7 matches the last loaded byte, bit 6 still and the load window over
          if (rdata_r[7] == last_r[7] && have_prev_r &&
              (prev_r[6] == rdata_r[6]) && win_r == 32'h0000_0000) begin
            busy_r <= 1'b0;
            done_r <= 1'b1;
            st_r   <= S_IDLE;
          end else if (tmo_r >= TIMEOUT_CYC) begin
            busy_r     <= 1'b0;
            tmo_flag_r <= 1'b1;
            done_r     <= 1'b1;
            st_r       <= S_IDLE;
          end else begin
            FL_ADDR       <= addr_r;
            FL_CHIP_SEL_N <= 1'b0;
            FL_OUT_GATE_N <= 1'b0;
            tmo_r         <= tmo_r + 32'd1;
            // from the second read on, prev_r holds a real earlier sample
            have_prev_r   <= 1'b1;
            st_r          <= S_RD;
          end
        end
        default: st_r <= S_IDLE;
      endcase
    end
  end
endmodule // flash_host
`default_nettype wire

// File: bench/flash_host_checker.sv
// port checks for the flash host controller
`timescale 1ns/1ps
`default_nettype none
module flash_host_checker #(
  parameter [31:0] LOCKOUT_CYC = 32'h0000_0032
) (
  input wire logic        REF_CLK,
  input wire logic        ARST_N,
  input wire logic        S_ARVALID,
  input wire logic        S_ARREADY,
  input wire logic        S_RVALID,
  input wire logic [15:0] FL_ADDR,
  input wire logic        FL_CHIP_SEL_N,
  input wire logic        FL_OUT_GATE_N,
  input wire logic        FL_WR_STROBE_N,
  input wire logic [7:0]  FL_DQ_O,
  input wire logic        FL_DQ_OE
);
  logic [31:0] up_r;
  // counts from reset release, stops once the lockout span is over
  always @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) up_r <= 32'h0000_0000;
    else if (up_r < LOCKOUT_CYC) up_r <= up_r + 32'h0000_0001;
  end
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!ARST_N);
  sequence load_on; !FL_WR_STROBE_N && !FL_CHIP_SEL_N; endsequence
  sequence ar_take; S_ARVALID && S_ARREADY; endsequence
  gate_high_a: assert property (load_on |-> FL_OUT_GATE_N)
    else $error("gate low in a load");
  read_mode_a: assert property (!FL_OUT_GATE_N |->
    !FL_CHIP_SEL_N && FL_WR_STROBE_N && !FL_DQ_OE) else $error("bad read");
  strobe_sel_a: assert property (!FL_WR_STROBE_N |-> load_on)
    else $error("strobe without select");
  data_hold_a: assert property ($rose(FL_WR_STROBE_N) |->
    FL_DQ_OE && $stable(FL_DQ_O)) else $error("data moved at rise");
  addr_hold_a: assert property (load_on ##1 load_on |->
    $stable(FL_ADDR)) else $error("address moved in a load");
  pulse_len_a: assert property ($fell(FL_WR_STROBE_N) |->
    !FL_WR_STROBE_N [*5]) else $error("strobe pulse short");
  lockout_a: assert property (up_r < LOCKOUT_CYC |->
    FL_WR_STROBE_N) else $error("load in lockout");
  read_ans_a: assert property (ar_take |-> ##[1:2] S_RVALID)
    else $error("read answer late");
endmodule // flash_host_checker
bind flash_host flash_host_checker #(.LOCKOUT_CYC(LOCKOUT_CYC)) chk_u (.*);
`default_nettype wire

// File: bench/sector_flash_model.sv
// behavioural byte-wide sector flash facing the host
`timescale 1ns/1ps
`default_nettype none
module sector_flash_model #(
  parameter int WIN_NS  = 1600,
  parameter int PROG_NS = 4000,
  parameter int LOCK_NS = 150
) (
  input  wire logic [15:0] addr,
  input  wire logic        cs_n,
  input  wire logic        oe_n,
  input  wire logic        we_n,
  input  wire logic        host_oe,
  input  wire logic [7:0]  host_d,
  output var  logic [7:0]  bus
);
  logic [7:0]   mem [0:65535];
  logic [7:0]   page [0:127];
  logic [127:0] got = '0;
  logic [15:0]  la;
  logic [7:0]   ld, junk = 8'h5A;
  logic         busy = 1'b0, pend = 1'b0, tgl = 1'b0;
  realtime      t_fall, t_rise;
  wire          lo = !cs_n && !we_n && oe_n;
  wire          rd = !cs_n && !oe_n && we_n;
  // a released bus must not keep showing its last value
  always #4 junk = ~junk;
  always @(posedge lo) begin
    la = addr;
    t_fall = $realtime;
  end
  // byte at first rise, any order
  always @(negedge lo) begin
    if ($realtime - t_fall >= 15 && $realtime >= LOCK_NS && !busy) begin
      page[la[6:0]] = host_d;
      got[la[6:0]] = 1'b1;
      ld = host_d;
      t_rise = $realtime;
      pend = 1'b1;
    end
  end
  // quiet window starts the sector rewrite
  always #20 begin
    if (pend && $realtime - t_rise > WIN_NS) begin
      pend = 1'b0;
      busy = 1'b1;
      for (int i = 0; i < 128; i++)
        mem[{la[15:7], i[6:0]}] = got[i] ? page[i] : 8'hxx;
      got = '0;
      #PROG_NS busy = 1'b0;
    end
  end
  // each read while busy flips the line
  always @(posedge rd) if (busy) tgl = ~tgl;
  always @* begin
    if (host_oe) bus = host_d;
    else if (rd && busy) bus = {~ld[7], tgl, junk[5:0]};
    else if (rd) bus = mem[addr];
    else bus = junk;
  end
endmodule // sector_flash_model
`default_nettype wire

// File: bench/flash_host_test.sv
// self-checking bench for the flash host controller
`timescale 1ns/1ps
`default_nettype none
`include "flash_host_map.vh"
module flash_host_test;
  logic        clk = 1'b0, rst_n = 1'b0, awv = 1'b0, wv = 1'b0;
  logic        bready = 1'b0, arv = 1'b0, rready = 1'b0;
  logic [7:0]  awa = 8'h00, ara = 8'h00, exp_d [0:127];
  logic [31:0] wd = 32'h0000_0000, st, d;
  logic [1:0]  r;
  wire  [31:0] rdata;
  wire  [15:0] fa;
  wire  [7:0]  dq_o, bus;
  wire  [1:0]  bresp, rresp;
  wire         awr, wr, bv, arr, rv, cs_n, oe_n, we_n, dq_oe;
  int          err_total = 0, cmp_count = 0, falls = 0;
  flash_host #(.LOAD_WIN_CYC(32'h0000_01F4), .LOCKOUT_CYC(32'h0000_0032),
    .TIMEOUT_CYC(32'h0000_07D0)) dut_u (
    .REF_CLK(clk), .ARST_N(rst_n), .S_AWADDR(awa), .S_AWVALID(awv),
    .S_AWREADY(awr), .S_WDATA(wd), .S_WSTRB(4'hF), .S_WVALID(wv),
    .S_WREADY(wr), .S_BRESP(bresp), .S_BVALID(bv), .S_BREADY(bready),
    .S_ARADDR(ara), .S_ARVALID(arv), .S_ARREADY(arr), .S_RDATA(rdata),
    .S_RRESP(rresp), .S_RVALID(rv), .S_RREADY(rready), .FL_ADDR(fa),
    .FL_CHIP_SEL_N(cs_n), .FL_OUT_GATE_N(oe_n), .FL_WR_STROBE_N(we_n),
    .FL_DQ_O(dq_o), .FL_DQ_OE(dq_oe), .FL_DQ_I(bus));
  sector_flash_model fl_u (.addr(fa), .cs_n(cs_n), .oe_n(oe_n),
    .we_n(we_n), .host_oe(dq_oe), .host_d(dq_o), .bus(bus));
  initial forever #2 clk = ~clk;
  always @(negedge we_n) falls++;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    {awa, wd, awv, wv, bready} <= {a, v, 3'b111};
    do begin
      @(posedge clk);
      {awv, wv} <= {awv & ~awr, wv & ~wr};
    end while (!bv);
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic axr(input logic [7:0] a);
    @(posedge clk);
    {ara, arv, rready} <= {a, 2'b11};
    do begin
      @(posedge clk);
      arv <= arv & ~arr;
    end while (!rv);
    {d, r} = {rdata, rresp};
    rready <= 1'b0;
  endtask
  task automatic op(input logic [15:0] a, input logic [7:0] v,
      input logic [31:0] c);
    axw(`REG_ADDR, {16'h0000, a});
    axw(`REG_WDATA, {24'h00_0000, v});
    axw(`REG_CMD, c);
    do axr(`REG_STATUS); while (d[`ST_DONE] !== 1'b1);
    st = d;
    axw(`REG_STATUS, 32'h0000_0006);
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (80000) @(posedge clk);
    err_total++;
    print_verdict();
  end
  initial begin
    logic [8:0] sec;
    logic [6:0] k, off;
    d = $urandom(32'h0000_21B5);
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    axw(`REG_CMD, {29'h0000_0000, `CMD_LOAD});
    check({30'h0000_0000, r}, 32'h0000_0000);
    axr(`REG_STATUS);
    check(d & 32'h0000_0007, 32'h0000_0000);
    axr(`REG_PREFIX);
    check({30'h0000_0000, r}, 32'h0000_0002);
    repeat (60) @(posedge clk);
    for (int s = 0; s < 3; s++) begin
      falls = 0;
      op(16'h0000, 8'h00, {26'h000_0000, 2'(s), 1'b0, `CMD_SEQ});
      check(falls, s == 2 ? 6 : 3);
      op(16'h0000, 8'h00, {29'h0000_0000, `CMD_POLL});
      check(st & 32'h0000_0004, 32'h0000_0000);
    end
    sec = 9'($urandom_range(511, 1));
    k = 7'($urandom);
    for (int i = 0; i < 128; i++) begin
      off = 7'(i * 37) + k;
      exp_d[off] = 8'($urandom);
      op({sec, off}, exp_d[off], {29'h0000_0000, `CMD_LOAD});
    end
    op({sec, off}, exp_d[off], {29'h0000_0000, `CMD_POLL});
    check(st & 32'h0000_0004, 32'h0000_0000);
    for (int j = 0; j < 10; j++) begin
      off = j < 2 ? 7'(j * 127) : 7'($urandom);
      op({sec, off}, 8'h00, {29'h0000_0000, `CMD_READ});
      axr(`REG_RDATA);
      check(d & 32'h0000_00FF, {24'h00_0000, exp_d[off]});
    end
    print_verdict();
  end
endmodule // flash_host_test
`default_nettype wire
